/* File: src/acm_cfg.svh */
/*
 Defines for the channel and calibration mode control block: register
 select codes, field positions, reset values, timing counts.
 Assumes inclusion by bare name from the package and the design file.
*/
`ifndef ACM_CFG_SVH
`define ACM_CFG_SVH

// =====================================================================
// Register select codes
`define ACM_RS_COMM        3'h0
`define ACM_RS_MODE        3'h1
`define ACM_RS_ZERO_CAL    3'h6
`define ACM_RS_FULL_CAL    3'h7

// =====================================================================
// Reset values
`define ACM_CHAN_RESET     3'h4
`define ACM_MODE_RESET     8'h00

// =====================================================================
// Mode field codes
`define ACM_MD_NORMAL      3'h0
`define ACM_MD_SELF_CAL    3'h1
`define ACM_MD_ZERO_SYS    3'h2
`define ACM_MD_FULL_SYS    3'h3

// =====================================================================
// Field positions in the communications register
`define ACM_COMM_READY_BIT 7

// =====================================================================
// Timing
`define ACM_CAL_STEP_CYCLES 16'h0100

`endif

/* File: src/acm_ctrl.sv */
/*
 Channel select decode, calibration register pairs and operating mode
 register with self-clearing calibration sequencer.
 Assumes the serial framing logic hands over decoded register accesses
 as one-cycle strobes, and the modulator/filter deliver measurement
 words with a one-cycle valid.
*/
// Summary of operation
// [R1] Channel field picks conversion input and calibration pair accessed
// [R2] Three calibration pairs, each one zero-scale and one full-scale word
// [R3] Codes 100, 101, 110 use pairs 0, 1, 2
// [R4] Codes 000-011 pseudo-differential against input six, pairs 0,1,2,2
// [R5] Code 111 shorts input six to itself, pair 2
// [R6] Reset sets channel field to 100
// [R7] Mode register eight bits, read/write at select code 001
// [R8] Mode register resets to 0x00
// [R9] Mode bits: mode field, gain field, burnout, filter sync
// [R10] Mode 000 is continuous normal conversion
// [R11] Mode 001 self-calibrates then returns mode field to 000
// [R12] Self-cal: shorted inputs for zero, reference over gain for full
// [R13] Mode 010 zero-scale system calibration on external input
// [R14] Mode 011 full-scale system calibration on external input
// [R15] System calibrations clear mode field to 000 on completion
// [R16] Ready flag high at calibration start, low after new result
// [R17] Communications read MSB equals the ready output
// [R18] Calibration results written into the channel's mapped pair
// [R19] Host waits for ready low before next calibration or read
`timescale 1ns/100ps
`include "acm_cfg.svh"

module acm_ctrl #(
   parameter int unsigned CAL_STEP_CYCLES = `ACM_CAL_STEP_CYCLES
) (
   input  wire logic             ref_clk,
   input  wire logic             rst,
   input  wire acm_pkg::acm_req_s req,
   output logic [23:0]           rd_data,
   output logic                  result_available_flag,
   output acm_pkg::acm_chan_s    chan,
   output logic [2:0]            gain_select_field,
   output logic                  burnout_control_bit,
   output logic                  filter_sync_bit,
   output logic                  cal_active,
   output logic                  cal_zero_phase,
   output logic                  cal_internal_ref,
   input  wire logic             meas_valid,
   input  wire logic [23:0]      meas_word,
   output logic [23:0]           data_word
);

   // ==================================================================
   // State
   typedef struct packed {
      logic [2:0]          channel_select_field;
      acm_pkg::acm_mode_s  mode;
      acm_pkg::acm_state_e state;
      logic                self_cal;
      logic [15:0]         step_cnt;
      logic                ready_n;
      logic [2:0][23:0]    zero_coef;
      logic [2:0][23:0]    full_coef;
      logic [23:0]         rd_data;
      logic [23:0]         data_word;
   } acm_ctrl_s;

   acm_ctrl_s s_q;
   acm_ctrl_s s_d;
   acm_pkg::acm_chan_s chan_c;
   logic [15:0] step_last;
   logic [1:0]  pair;

   assign step_last = 16'(CAL_STEP_CYCLES - 1);

   // ==================================================================
   // Channel decode
   always_comb begin
      chan_c.fully_diff = s_q.channel_select_field[2];                 // R1
      chan_c.test_mode  = 1'b0;
      chan_c.neg_input  = 3'h6;
      chan_c.pos_input  = 3'h1;
      chan_c.cal_pair   = 2'h0;
      case (s_q.channel_select_field)
         3'h0: begin                                                // R4
            chan_c.pos_input = 3'h1;
            chan_c.cal_pair  = 2'h0;
         end
         3'h1: begin                                                // R4
            chan_c.pos_input = 3'h2;
            chan_c.cal_pair  = 2'h1;
         end
         3'h2: begin                                                // R4
            chan_c.pos_input = 3'h3;
            chan_c.cal_pair  = 2'h2;
         end
         3'h3: begin                                                // R4
            chan_c.pos_input = 3'h4;
            chan_c.cal_pair  = 2'h2;
         end
         3'h4: begin                                                // R3
            chan_c.pos_input = 3'h1;
            chan_c.neg_input = 3'h2;
            chan_c.cal_pair  = 2'h0;
         end
         3'h5: begin                                                // R3
            chan_c.pos_input = 3'h3;
            chan_c.neg_input = 3'h4;
            chan_c.cal_pair  = 2'h1;
         end
         3'h6: begin                                                // R3
            chan_c.pos_input = 3'h5;
            chan_c.neg_input = 3'h6;
            chan_c.cal_pair  = 2'h2;
         end
         default: begin                                             // R5
            chan_c.fully_diff = 1'b0;
            chan_c.test_mode  = 1'b1;
            chan_c.pos_input  = 3'h6;
            chan_c.neg_input  = 3'h6;
            chan_c.cal_pair   = 2'h2;
         end
      endcase
   end

   assign pair = chan_c.cal_pair;

   // ==================================================================
   // Next state
   always_comb begin
      s_d = s_q;

      // Register reads
      if (req.rd_en) begin
         if (req.register_select_field == `ACM_RS_COMM) begin
            s_d.rd_data = {16'h0000, s_q.ready_n,                    // R17
                           4'h0, s_q.channel_select_field};
         end else if (req.register_select_field == `ACM_RS_MODE) begin
            s_d.rd_data = {16'h0000, s_q.mode};                      // R7
         end else if (req.register_select_field == `ACM_RS_ZERO_CAL) begin
            s_d.rd_data = s_q.zero_coef[pair];                       // R1
         end else if (req.register_select_field == `ACM_RS_FULL_CAL) begin
            s_d.rd_data = s_q.full_coef[pair];
         end else begin
            s_d.rd_data = 24'h000000;
         end
      end

      // Calibration sequencer
      case (s_q.state)
         acm_pkg::ACM_ST_NORMAL: begin                               // R10
            if (meas_valid) begin
               s_d.data_word = meas_word;
               s_d.ready_n   = 1'b0;
            end
         end
         acm_pkg::ACM_ST_CAL_ZERO: begin
            if (s_q.step_cnt == step_last) begin
               s_d.step_cnt = 16'h0000;
               if (meas_valid) begin
                  s_d.zero_coef[pair] = meas_word;                  // R18
               end
               if (s_q.self_cal) begin
                  s_d.state = acm_pkg::ACM_ST_CAL_FULL;              // R11
               end else begin
                  s_d.state = acm_pkg::ACM_ST_CAL_RESULT;            // R13
               end
            end else begin
               s_d.step_cnt = 16'(s_q.step_cnt + 16'h0001);
            end
         end
         acm_pkg::ACM_ST_CAL_FULL: begin
            if (s_q.step_cnt == step_last) begin
               s_d.step_cnt = 16'h0000;
               if (meas_valid) begin
                  s_d.full_coef[pair] = meas_word;                  // R18
               end
               s_d.state = acm_pkg::ACM_ST_CAL_RESULT;               // R14
            end else begin
               s_d.step_cnt = 16'(s_q.step_cnt + 16'h0001);
            end
         end
         default: begin
            if (meas_valid) begin
               s_d.data_word = meas_word;
               s_d.ready_n   = 1'b0;                                 // R16
               s_d.mode.operating_mode_field = `ACM_MD_NORMAL;       // R15
               s_d.self_cal  = 1'b0;                                 // R12
               s_d.state = acm_pkg::ACM_ST_NORMAL;                   // R11
            end
         end
      endcase

      // Register writes
      if (req.wr_en) begin
         if (req.register_select_field == `ACM_RS_COMM) begin
            s_d.channel_select_field = req.wr_data[2:0];             // R1
         end else if (req.register_select_field == `ACM_RS_MODE) begin
            s_d.mode = req.wr_data[7:0];                             // R9
            s_d.step_cnt = 16'h0000;
            s_d.self_cal = 1'b0;
            case (req.wr_data[7:5])
               `ACM_MD_SELF_CAL: begin
                  s_d.self_cal = 1'b1;                               // R12
                  s_d.state    = acm_pkg::ACM_ST_CAL_ZERO;
                  s_d.ready_n  = 1'b1;                               // R16
               end
               `ACM_MD_ZERO_SYS: begin
                  s_d.state   = acm_pkg::ACM_ST_CAL_ZERO;            // R13
                  s_d.ready_n = 1'b1;                                // R16
               end
               `ACM_MD_FULL_SYS: begin
                  s_d.state   = acm_pkg::ACM_ST_CAL_FULL;            // R14
                  s_d.ready_n = 1'b1;                                // R16
               end
               default: begin
                  s_d.state = acm_pkg::ACM_ST_NORMAL;
               end
            endcase
         end else if (req.register_select_field == `ACM_RS_ZERO_CAL) begin
            s_d.zero_coef[pair] = req.wr_data;                       // R2
         end else if (req.register_select_field == `ACM_RS_FULL_CAL) begin
            s_d.full_coef[pair] = req.wr_data;                       // R2
         end
      end

      if (rst) begin
         s_d = '0;
         s_d.channel_select_field = `ACM_CHAN_RESET;                 // R6
         s_d.mode  = `ACM_MODE_RESET;                                // R8
         s_d.state = acm_pkg::ACM_ST_NORMAL;
         s_d.ready_n = 1'b1;
      end
   end

   always_ff @(posedge ref_clk) begin
      s_q <= s_d;
   end

   // ==================================================================
   // Outputs
   assign rd_data               = s_q.rd_data;
   assign data_word             = s_q.data_word;
   assign result_available_flag = s_q.ready_n;                       // R17
   assign chan                  = chan_c;
   assign gain_select_field     = s_q.mode.gain_select_field;
   assign burnout_control_bit   = s_q.mode.burnout_control_bit;
   assign filter_sync_bit       = s_q.mode.filter_sync_bit;
   assign cal_active     = (s_q.state != acm_pkg::ACM_ST_NORMAL);
   assign cal_zero_phase = (s_q.state == acm_pkg::ACM_ST_CAL_ZERO);
   assign cal_internal_ref = s_q.self_cal;                           // R12

endmodule : acm_ctrl

/* File: src/acm_pkg.sv */
/*
 Types for the channel and calibration mode control block.
 Assumes acm_cfg.svh is on the include path.
*/
`include "acm_cfg.svh"

package acm_pkg;

   // ==================================================================
   // Operating mode register layout
   typedef struct packed {
      logic [2:0] operating_mode_field;
      logic [2:0] gain_select_field;
      logic       burnout_control_bit;
      logic       filter_sync_bit;
   } acm_mode_s;

   typedef enum logic [1:0] {
      ACM_ST_NORMAL,
      ACM_ST_CAL_ZERO,
      ACM_ST_CAL_FULL,
      ACM_ST_CAL_RESULT
   } acm_state_e;

   typedef struct packed {
      logic       fully_diff;
      logic       test_mode;
      logic [2:0] pos_input;
      logic [2:0] neg_input;
      logic [1:0] cal_pair;
   } acm_chan_s;

   typedef struct packed {
      logic        wr_en;
      logic        rd_en;
      logic [2:0]  register_select_field;
      logic [23:0] wr_data;
   } acm_req_s;

   typedef struct packed {
      logic [2:0]  channel_select_field;
      acm_mode_s   mode;
      acm_state_e  state;
      logic [15:0] step_cnt;
      logic        result_available_flag;
      logic [2:0][23:0] zero_coef;
      logic [2:0][23:0] full_coef;
      logic [23:0] rd_data;
   } acm_unused_s;

endpackage : acm_pkg

/* File: tb/acm_ctrl_props.sv */
/*
 Checker for the channel and mode control block.
 Assumes the measurement source runs through every calibration.
*/
`timescale 1ns/100ps
`include "acm_cfg.svh"
module acm_ctrl_props #(
   parameter int unsigned CAL_STEP_CYCLES = 4
) (
   input wire logic               ref_clk,
   input wire logic               rst,
   input wire acm_pkg::acm_req_s  req,
   input wire logic [23:0]        rd_data,
   input wire logic               result_available_flag,
   input wire acm_pkg::acm_chan_s chan,
   input wire logic [2:0]         gain_select_field,
   input wire logic               burnout_control_bit,
   input wire logic               filter_sync_bit,
   input wire logic               cal_active,
   input wire logic               cal_zero_phase,
   input wire logic               cal_internal_ref
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   // Zero step, full step and result wait, with slack
   localparam int CAL_LIMIT = 2 * CAL_STEP_CYCLES + 8;
   logic       wm;
   logic [2:0] md;
   assign wm = req.wr_en && req.register_select_field == `ACM_RS_MODE
               && !cal_active;
   assign md = req.wr_data[7:5];
   property p_cal_start;
      wm && md inside {3'h1, 3'h2, 3'h3} |=> cal_active
         && result_available_flag;
   endproperty
   a_cal_start: assert property (p_cal_start) else $error("no cal");
   property p_self;
      wm && md == 3'h1 |=> cal_zero_phase && cal_internal_ref;
   endproperty
   a_self: assert property (p_self) else $error("self cal");
   property p_zsys;
      wm && md == 3'h2 |=> cal_zero_phase && !cal_internal_ref;
   endproperty
   a_zsys: assert property (p_zsys) else $error("zero sys");
   property p_fsys;
      wm && md == 3'h3 |=> !cal_zero_phase && !cal_internal_ref;
   endproperty
   a_fsys: assert property (p_fsys) else $error("full sys");
   property p_norm;
      wm && md == 3'h0 |=> !cal_active;
   endproperty
   a_norm: assert property (p_norm) else $error("normal");
   property p_fields;
      wm |=> gain_select_field == $past(req.wr_data[4:2])
         && burnout_control_bit == $past(req.wr_data[1])
         && filter_sync_bit == $past(req.wr_data[0]);
   endproperty
   a_fields: assert property (p_fields) else $error("mode bits");
   property p_comm;
      req.rd_en && req.register_select_field == `ACM_RS_COMM |=>
         rd_data[23:8] == 16'h0000
         && rd_data[7] == $past(result_available_flag);
   endproperty
   a_comm: assert property (p_comm) else $error("comm read");
   property p_test;
      chan.test_mode |-> chan.cal_pair == 2'h2
         && chan.pos_input == chan.neg_input;
   endproperty
   a_test: assert property (p_test) else $error("test chan");
   property p_flag_cal;
      cal_active |-> result_available_flag;
   endproperty
   a_flag_cal: assert property (p_flag_cal) else $error("flag");
   property p_end;
      $fell(cal_active) |-> !result_available_flag;
   endproperty
   a_end: assert property (p_end) else $error("cal end");
   property p_bound;
      $rose(cal_active) |-> ##[1:CAL_LIMIT] !cal_active;
   endproperty
   a_bound: assert property (p_bound) else $error("cal hang");
   property p_ref_idle;
      !cal_active |-> !cal_internal_ref;
   endproperty
   a_ref_idle: assert property (p_ref_idle) else $error("ref idle");
endmodule : acm_ctrl_props
bind acm_ctrl acm_ctrl_props #(.CAL_STEP_CYCLES(CAL_STEP_CYCLES))
   u_acm_ctrl_props (.ref_clk, .rst, .req, .rd_data,
   .result_available_flag, .chan, .gain_select_field,
   .burnout_control_bit, .filter_sync_bit, .cal_active,
   .cal_zero_phase, .cal_internal_ref);

/* File: tb/acm_meas_src.sv */
/*
 Measurement source model: one word per cycle while enabled.
 Assumes the bench owns the enable and the shared clock and reset.
*/
`timescale 1ns/100ps
module acm_meas_src (
   input  wire logic        ref_clk,
   input  wire logic        rst,
   input  wire logic        en,
   output logic             meas_valid,
   output logic [23:0]      meas_word
);
   // Words never zero, so a captured coefficient is seen
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         meas_valid <= 1'b0;
         meas_word  <= 24'h000100;
      end else begin
         meas_valid <= en;
         meas_word  <= meas_word + 24'h000001;
      end
   end
endmodule : acm_meas_src

/* File: tb/tb_acm_ctrl.sv */
/*
 Testbench for the channel and mode control block.
 Assumes the design and checker files are compiled first.
*/
`timescale 1ns/100ps
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin \
   fails++; $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module tb_acm_ctrl;
   logic               ref_clk, rst, en, meas_valid, cal_active;
   logic [23:0]        meas_word, rd_data, q, z2, dw;
   acm_pkg::acm_req_s  req;
   acm_pkg::acm_chan_s chan;
   logic [2:0]         gain;
   logic               flag, bo, fs;
   int                 fails, tests_run, cyc;
   acm_ctrl #(.CAL_STEP_CYCLES(4)) u_acm_ctrl (.ref_clk, .rst, .req,
      .rd_data, .result_available_flag(flag), .chan,
      .gain_select_field(gain), .burnout_control_bit(bo),
      .filter_sync_bit(fs), .cal_active, .cal_zero_phase(),
      .cal_internal_ref(), .meas_valid, .meas_word, .data_word(dw));
   acm_meas_src u_acm_meas_src (.ref_clk, .rst, .en, .meas_valid,
      .meas_word);
   initial begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end
   task automatic wr(input logic [2:0] rs, input logic [23:0] d);
      @(negedge ref_clk);
      req = '{1'b1, 1'b0, rs, d};
      @(negedge ref_clk);
      req.wr_en = 1'b0;
   endtask : wr
   task automatic rd(input logic [2:0] rs, output logic [23:0] d);
      @(negedge ref_clk);
      req = '{1'b0, 1'b1, rs, 24'h0};
      @(negedge ref_clk);
      req.rd_en = 1'b0;
      d = rd_data;
   endtask : rd
   task automatic cal_wait();
      repeat (2) @(negedge ref_clk);
      for (int i = 0; i < 100 && cal_active !== 1'b0; i++)
         @(negedge ref_clk);
      `CHK("flag", 1'b0, flag)
      `CHK("data", meas_word - 24'h000001, dw)
   endtask : cal_wait
   task automatic t_reset();
      rd(3'h0, q);
      `CHK("comm", 24'h000084, q)
      rd(3'h1, q);
      `CHK("mode", 24'h000000, q)
      `CHK("pair", 2'h0, chan.cal_pair)
      `CHK("fd", 1'b1, chan.fully_diff)
      rd(3'h6, q);
      `CHK("zcoef", 24'h000000, q)
      $display("t_reset done");
   endtask : t_reset
   task automatic t_chan();
      logic [1:0] pr [8] = '{2'h0, 2'h1, 2'h2, 2'h2, 2'h0, 2'h1, 2'h2, 2'h2};
      for (int i = 0; i < 8; i++) begin
         wr(3'h0, 24'(i));
         `CHK("pair", pr[i], chan.cal_pair)
         `CHK("fd", 1'(i inside {[4:6]}), chan.fully_diff)
         `CHK("test", 1'(i == 7), chan.test_mode)
      end
      $display("t_chan done");
   endtask : t_chan
   task automatic t_mode();
      wr(3'h1, 24'h00001f);
      rd(3'h1, q);
      `CHK("mode", 24'h00001f, q)
      `CHK("gain", 3'h7, gain)
      `CHK("bo_fs", 2'h3, {bo, fs})
      wr(3'h2, 24'h000055);
      rd(3'h2, q);
      `CHK("unmapped", 24'h000000, q)
      wr(3'h1, 24'h0000e0);
      `CHK("md7", 1'b0, cal_active)
      rd(3'h1, q);
      `CHK("mode7", 24'h0000e0, q)
      $display("t_mode done");
   endtask : t_mode
   task automatic t_cal();
      en = 1'b1;
      wr(3'h0, 24'h000002);
      wr(3'h1, 24'h000020);
      cal_wait();
      rd(3'h1, q);
      `CHK("md", 3'h0, q[7:5])
      rd(3'h6, z2);
      `CHK("z2", 1'b1, !$isunknown(z2) && z2 != 24'h0)
      rd(3'h7, q);
      `CHK("f2", z2 + 24'h000004, q)
      wr(3'h0, 24'h000003);
      rd(3'h6, q);
      `CHK("z3", z2, q)
      wr(3'h0, 24'h000000);
      rd(3'h6, q);
      `CHK("z0", 24'h000000, q)
      for (int m = 2; m < 4; m++) begin
         wr(3'h1, {16'h0, 3'(m), 5'h08});
         cal_wait();
         rd(3'h1, q);
         `CHK("md_sys", 24'h000008, q)
         rd(3'(m + 4), q);
         `CHK("sys_coef", 1'b1, !$isunknown(q) && q != 24'h0)
      end
      $display("t_cal done");
   endtask : t_cal
   task automatic t_rerun();
      en = 1'b0;
      wr(3'h0, 24'h000001);
      wr(3'h1, 24'h000040);
      @(negedge ref_clk);
      rst = 1'b1;
      repeat (2) @(negedge ref_clk);
      rst = 1'b0;
      `CHK("cal_rst", 1'b0, cal_active)
      rd(3'h0, q);
      `CHK("comm_rst", 24'h000084, q)
      rd(3'h1, q);
      `CHK("mode_rst", 24'h000000, q)
      $display("t_rerun done");
   endtask : t_rerun
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : give_verdict
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 5000) begin
         fails++;
         give_verdict();
      end
   end
   initial begin
      rst = 1'b1;
      en = 1'b0;
      req = '0;
      repeat (8) @(posedge ref_clk);
      @(negedge ref_clk);
      rst = 1'b0;
      t_reset();
      t_chan();
      t_mode();
      t_cal();
      t_rerun();
      give_verdict();
   end
endmodule : tb_acm_ctrl
